// File: rtl/fbsig_pkg.sv
package fbsig_pkg;

  localparam int CLK_HZ          = 40_000_000;
  // fast burst: about ten flashes per second, so one half period is 50 ms
  localparam int FAST_HALF_MS    = 50;
  localparam int FAST_HALF_CYC   = CLK_HZ / 1000 * FAST_HALF_MS;
  // slow series: about one flash per second, so one half period is 500 ms
  localparam int SLOW_HALF_MS    = 500;
  localparam int SLOW_HALF_CYC   = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam int PAUSE_MS        = 1500;
  localparam int PAUSE_CYC       = CLK_HZ / 1000 * PAUSE_MS;
  localparam int WDOG_MS         = 100;
  localparam int WDOG_CYC        = CLK_HZ / 1000 * WDOG_MS;
  localparam int STARTUP_MS      = 1500;
  localparam int STARTUP_CYC     = CLK_HZ / 1000 * STARTUP_MS;
  localparam int FAST_FLASHES    = 10;

  localparam logic [3:0] CODE_HW     = 4'h1;
  localparam logic [3:0] CODE_CFG    = 4'h2;
  localparam logic [3:0] CODE_CMD    = 4'h3;
  localparam logic [3:0] CODE_DATA   = 4'h4;
  localparam logic [3:0] CODE_REG    = 4'h5;
  localparam logic [3:0] CODE_FBUS   = 4'h6;
  localparam logic [3:0] CODE_MOD    = 4'h7;
  localparam logic [3:0] CODE_RSV8   = 4'h8;
  localparam logic [3:0] CODE_RSV9   = 4'h9;
  localparam logic [3:0] CODE_RUN    = 4'hA;

  localparam logic [7:0] ARG_MAX_HW   = 8'h0D;
  localparam logic [7:0] ARG_MAX_CFG  = 8'h03;
  localparam logic [7:0] ARG_MAX_FBUS = 8'h08;
  localparam logic [7:0] ARG_MAX_RUN  = 8'h03;

  localparam logic [15:0] FBUS_ERR_NONE = 16'h0000;
  localparam logic [15:0] FBUS_ERR_FAIL = 16'h0001;

  typedef enum logic [2:0] {
    FBSIG_BOOT  = 3'b000,
    FBSIG_OK    = 3'b001,
    FBSIG_BURST = 3'b010,
    FBSIG_P1    = 3'b011,
    FBSIG_CODE  = 3'b100,
    FBSIG_P2    = 3'b101,
    FBSIG_ARG   = 3'b110,
    FBSIG_P3    = 3'b111
  } fbsig_phase_t;

  typedef struct packed {
    logic [3:0] code;
    logic [7:0] arg;
  } fbsig_fault_t;

  typedef struct packed {
    logic lampGreen;
    logic lampRed;
  } fbsig_lamp_t;

endpackage

// File: rtl/fbsig_signaller.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - each display opens with a fast burst near ten flashes per second
// - after a pause, slow flashes at one per second count the code
// - after a second pause, slow flashes count the fault argument
// - code 1 is hardware faults, arguments 1 to 13
// - code 2 is configuration faults, arguments 1 to 3
// - code 3 is bus command fault with argument zero, no argument series
// - code 4 is bus data fault; argument n means broken after module n
// - code 5 is register communication fault after module n
// - code 6 is fieldbus faults, arguments 1 to 8
// - code 7 is unsupported module at position n
// - codes 8 and 9 are reserved and never shown
// - code 10 is runtime errors, arguments 1 to 3
// - modules without process data are skipped when counting positions
// - on fieldbus failure outputs hold unless a watchdog is configured
// - every successful transfer restarts the watchdog
// - on expiry flag is true and word is 1; otherwise false and 0
// - after timeout outputs take the application-configured safe state
// - burst, code and argument series repeat while the fault persists
// - fast flash during bus start-up, steady green if clean, else code
// - fault codes show red and clear only at a full restart
module fbsig_signaller #(
  parameter int PAUSE_CYCLES   = fbsig_pkg::PAUSE_CYC,
  parameter int WDOG_CYCLES    = fbsig_pkg::WDOG_CYC,
  parameter int FAST_CYCLES    = fbsig_pkg::FAST_HALF_CYC,
  parameter int SLOW_CYCLES    = fbsig_pkg::SLOW_HALF_CYC,
  parameter int STARTUP_CYCLES = fbsig_pkg::STARTUP_CYC,
  parameter int OUT_W          = 16
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   busInitDone,
  input  wire logic                   faultValid,
  input  wire fbsig_pkg::fbsig_fault_t faultIn,
  input  wire logic [63:0]            moduleHasData,
  input  wire logic [5:0]             moduleIndex,
  input  wire logic                   xferOk,
  input  wire logic                   wdogEnable,
  input  wire logic [OUT_W-1:0]       fbusOutputs,
  input  wire logic [OUT_W-1:0]       safeOutputs,
  output logic                        lampRed,
  output logic                        lampGreen,
  output logic                        fieldbus_failure_flag,
  output logic [15:0]                 fieldbusErrorWord,
  output logic [OUT_W-1:0]            fieldOutputs,
  output logic [3:0]                  shownCode,
  output logic [7:0]                  shownArg
);

  localparam int CW = 32;

  typedef struct packed {
    fbsig_pkg::fbsig_phase_t phase;
    logic [CW-1:0]           timer;
    logic [CW-1:0]           wdog;
    logic [CW-1:0]           boot;
    logic [7:0]              left;
    logic                    lit;
    logic                    latched;
    fbsig_pkg::fbsig_fault_t fault;
    fbsig_pkg::fbsig_lamp_t  lamp;
    logic                    fail;
    logic [15:0]             errWord;
    logic [OUT_W-1:0]        outs;
    logic                    initSync1;
    logic                    initSync2;
  } fbsig_state_t;

  fbsig_state_t st_ff;
  fbsig_state_t nxt_st;

  // counts modules with process data at or below the raw slot index
  function automatic logic [7:0] fbsig_position(input logic [63:0] has,
                                                input logic [5:0]  idx);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 64; i++) begin
      if ((i[5:0] <= idx) && has[i]) begin
        n = n + 8'h01;
      end
    end
    return n;
  endfunction

  // screens a reported fault against the catalogue; zero code means drop it
  function automatic fbsig_pkg::fbsig_fault_t fbsig_screen(
      input fbsig_pkg::fbsig_fault_t f,
      input logic [7:0]              pos);
    fbsig_pkg::fbsig_fault_t r;
    r = f;
    unique case (f.code)
      fbsig_pkg::CODE_HW: begin
        if (f.arg == 8'h00 || f.arg > fbsig_pkg::ARG_MAX_HW) begin
          r.code = 4'h0;
        end
      end
      fbsig_pkg::CODE_CFG: begin
        if (f.arg == 8'h00 || f.arg > fbsig_pkg::ARG_MAX_CFG) begin
          r.code = 4'h0;
        end
      end
      fbsig_pkg::CODE_CMD: begin
        r.arg = 8'h00;
      end
      fbsig_pkg::CODE_DATA: begin
        r.arg = (f.arg == 8'h00) ? 8'h00 : pos;
      end
      fbsig_pkg::CODE_REG: begin
        r.arg = pos;
      end
      fbsig_pkg::CODE_FBUS: begin
        if (f.arg == 8'h00 || f.arg > fbsig_pkg::ARG_MAX_FBUS) begin
          r.code = 4'h0;
        end
      end
      fbsig_pkg::CODE_MOD: begin
        r.arg = pos;
      end
      fbsig_pkg::CODE_RUN: begin
        if (f.arg == 8'h00 || f.arg > fbsig_pkg::ARG_MAX_RUN) begin
          r.code = 4'h0;
        end
      end
      default: begin
        r.code = 4'h0;
      end
    endcase
    return r;
  endfunction

  fbsig_pkg::fbsig_fault_t screened;
  logic                    timerDone;
  logic [CW-1:0]           halfLen;

  always_comb begin
    screened = fbsig_screen(faultIn, fbsig_position(moduleHasData,
                                                    moduleIndex));
    timerDone = (st_ff.timer == '0);
    // the burst uses the short half period, both counted series the long
    if (st_ff.phase == fbsig_pkg::FBSIG_BURST) begin
      halfLen = CW'(FAST_CYCLES - 1);
    end else begin
      halfLen = CW'(SLOW_CYCLES - 1);
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.initSync1 = busInitDone;
    nxt_st.initSync2 = st_ff.initSync1;

    if (!timerDone) begin
      nxt_st.timer = st_ff.timer - CW'(1);
    end

    // first fault wins; later reports cannot replace it before a restart
    if (faultValid && !st_ff.latched && screened.code != 4'h0) begin
      nxt_st.latched = 1'b1;
      nxt_st.fault   = screened;
    end

    unique case (st_ff.phase)
      fbsig_pkg::FBSIG_BOOT: begin
        if (st_ff.boot != '0) begin
          nxt_st.boot = st_ff.boot - CW'(1);
        end
        if (timerDone) begin
          nxt_st.timer = CW'(FAST_CYCLES - 1);
          nxt_st.lit   = ~st_ff.lit;
        end
        if (st_ff.latched && st_ff.initSync2) begin
          nxt_st.phase = fbsig_pkg::FBSIG_BURST;
          nxt_st.left  = 8'(fbsig_pkg::FAST_FLASHES);
          nxt_st.timer = CW'(FAST_CYCLES - 1);
          nxt_st.lit   = 1'b1;
        end else if (st_ff.initSync2 && st_ff.boot == '0) begin
          nxt_st.phase = fbsig_pkg::FBSIG_OK;
        end
      end
      fbsig_pkg::FBSIG_OK: begin
        nxt_st.lit = 1'b0;
        if (st_ff.latched) begin
          nxt_st.phase = fbsig_pkg::FBSIG_BURST;
          nxt_st.left  = 8'(fbsig_pkg::FAST_FLASHES);
          nxt_st.timer = CW'(FAST_CYCLES - 1);
          nxt_st.lit   = 1'b1;
        end
      end
      fbsig_pkg::FBSIG_BURST, fbsig_pkg::FBSIG_CODE,
      fbsig_pkg::FBSIG_ARG: begin
        if (timerDone) begin
          nxt_st.timer = halfLen;
          if (st_ff.lit) begin
            nxt_st.lit  = 1'b0;
            nxt_st.left = st_ff.left - 8'h01;
          end else if (st_ff.left != 8'h00) begin
            nxt_st.lit = 1'b1;
          end else begin
            nxt_st.timer = CW'(PAUSE_CYCLES - 1);
            if (st_ff.phase == fbsig_pkg::FBSIG_BURST) begin
              nxt_st.phase = fbsig_pkg::FBSIG_P1;
            end else if (st_ff.phase == fbsig_pkg::FBSIG_CODE) begin
              nxt_st.phase = fbsig_pkg::FBSIG_P2;
            end else begin
              nxt_st.phase = fbsig_pkg::FBSIG_P3;
            end
          end
        end
      end
      fbsig_pkg::FBSIG_P1: begin
        if (timerDone) begin
          nxt_st.phase = fbsig_pkg::FBSIG_CODE;
          nxt_st.left  = {4'h0, st_ff.fault.code};
          nxt_st.timer = CW'(SLOW_CYCLES - 1);
          nxt_st.lit   = 1'b1;
        end
      end
      fbsig_pkg::FBSIG_P2: begin
        if (timerDone) begin
          if (st_ff.fault.arg == 8'h00) begin
            nxt_st.phase = fbsig_pkg::FBSIG_P3;
            nxt_st.timer = CW'(PAUSE_CYCLES - 1);
          end else begin
            nxt_st.phase = fbsig_pkg::FBSIG_ARG;
            nxt_st.left  = st_ff.fault.arg;
            nxt_st.timer = CW'(SLOW_CYCLES - 1);
            nxt_st.lit   = 1'b1;
          end
        end
      end
      fbsig_pkg::FBSIG_P3: begin
        if (timerDone) begin
          nxt_st.phase = fbsig_pkg::FBSIG_BURST;
          nxt_st.left  = 8'(fbsig_pkg::FAST_FLASHES);
          nxt_st.timer = CW'(FAST_CYCLES - 1);
          nxt_st.lit   = 1'b1;
        end
      end
    endcase

    if (st_ff.phase == fbsig_pkg::FBSIG_OK) begin
      nxt_st.lamp.lampGreen = !st_ff.latched;
      nxt_st.lamp.lampRed   = 1'b0;
    end else begin
      // start-up and fault display only ever light red
      nxt_st.lamp.lampGreen = 1'b0;
      nxt_st.lamp.lampRed   = st_ff.lit;
    end

    // held at full period in start-up, so any exit starts a fresh timeout
    if (st_ff.phase == fbsig_pkg::FBSIG_BOOT) begin
      nxt_st.wdog = CW'(WDOG_CYCLES - 1);
    end else if (!wdogEnable) begin
      nxt_st.wdog = CW'(WDOG_CYCLES - 1);
      nxt_st.fail = 1'b0;
    end else if (xferOk) begin
      nxt_st.wdog = CW'(WDOG_CYCLES - 1);
      nxt_st.fail = 1'b0;
    end else if (st_ff.wdog != '0) begin
      nxt_st.wdog = st_ff.wdog - CW'(1);
    end else begin
      nxt_st.fail = 1'b1;
    end

    if (nxt_st.fail) begin
      nxt_st.errWord = fbsig_pkg::FBUS_ERR_FAIL;
      nxt_st.outs    = safeOutputs;
    end else begin
      nxt_st.errWord = fbsig_pkg::FBUS_ERR_NONE;
      if (xferOk) begin
        nxt_st.outs = fbusOutputs;
      end
    end
    // no update without a good transfer: outputs simply hold
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff       <= '0;
      st_ff.phase <= fbsig_pkg::FBSIG_BOOT;
      st_ff.boot  <= CW'(STARTUP_CYCLES - 1);
      st_ff.wdog  <= CW'(WDOG_CYCLES - 1);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lampRed               = st_ff.lamp.lampRed;
  assign lampGreen             = st_ff.lamp.lampGreen;
  assign fieldbus_failure_flag = st_ff.fail;
  assign fieldbusErrorWord     = st_ff.errWord;
  assign fieldOutputs          = st_ff.outs;
  assign shownCode             = st_ff.fault.code;
  assign shownArg              = st_ff.fault.arg;

endmodule // fbsig_signaller

`default_nettype wire

// File: sim/fbsig_properties.sv
`timescale 1ns/10ps
`default_nettype none
module fbsig_properties #(
  parameter int WDOG_CYCLES = 10,
  parameter int OUT_W       = 16
) (
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  input wire logic                    faultValid,
  input wire fbsig_pkg::fbsig_fault_t faultIn,
  input wire logic                    xferOk,
  input wire logic                    wdogEnable,
  input wire logic [OUT_W-1:0]        fbusOutputs,
  input wire logic [OUT_W-1:0]        safeOutputs,
  input wire logic                    lampRed,
  input wire logic                    fieldbus_failure_flag,
  input wire logic [15:0]             fieldbusErrorWord,
  input wire logic [OUT_W-1:0]        fieldOutputs,
  input wire logic [3:0]              shownCode,
  input wire logic [7:0]              shownArg
);
  int   idleCnt_ff;
  logic seen_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // idle time is only meaningful once a transfer armed the watchdog
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idleCnt_ff <= 0;
      seen_ff <= 1'b0;
    end else begin
      idleCnt_ff <= (xferOk || !wdogEnable) ? 0 : idleCnt_ff + 1;
      seen_ff <= wdogEnable && (seen_ff || xferOk);
    end
  end
  sequence sCmdTake;
    faultValid && shownCode == 4'h0 && faultIn.code == fbsig_pkg::CODE_CMD;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |->
    !lampRed && !fieldbus_failure_flag && shownCode == 4'h0)
    else $error("outputs active in reset");
  a_word_pairs: assert property (fieldbusErrorWord == (fieldbus_failure_flag ?
    fbsig_pkg::FBUS_ERR_FAIL : fbsig_pkg::FBUS_ERR_NONE))
    else $error("error word disagrees with flag");
  a_xfer_clears: assert property (xferOk |=> !fieldbus_failure_flag)
    else $error("flag kept after transfer");
  a_xfer_takes: assert property (xferOk |=> fieldOutputs == $past(fbusOutputs))
    else $error("transfer image not taken");
  a_safe_state: assert property (fieldbus_failure_flag && $stable(safeOutputs)
    |-> fieldOutputs == safeOutputs)
    else $error("outputs not safe after timeout");
  a_wdog_early: assert property (seen_ff && idleCnt_ff < WDOG_CYCLES - 2
    |-> !fieldbus_failure_flag)
    else $error("watchdog expired early");
  a_wdog_late: assert property (seen_ff && idleCnt_ff == WDOG_CYCLES + 4
    |-> fieldbus_failure_flag)
    else $error("watchdog did not expire");
  a_cmd_noarg: assert property (sCmdTake |-> ##2
    (shownCode == fbsig_pkg::CODE_CMD && shownArg == 8'h00))
    else $error("command fault shown wrongly");
  a_code_stands: assert property (shownCode != 4'h0 |=>
    $stable(shownCode) && $stable(shownArg))
    else $error("latched fault changed");
  a_no_reserved: assert property (shownCode <= fbsig_pkg::CODE_RUN &&
    shownCode != 4'h8 && shownCode != 4'h9)
    else $error("reserved code shown");
endmodule // fbsig_properties
`default_nettype wire

// File: sim/fbsig_lamp_observer.sv
`timescale 1ns/10ps
`default_nettype none
module fbsig_lamp_observer #(
  parameter int GAP = 12
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic lampRed,
  output int        flashCount,
  output logic      seriesDone
);
  int   cnt;
  int   offLen;
  logic prevRed;
  // a dark gap longer than any in-series off time ends a series
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      offLen <= 0;
      prevRed <= 1'b0;
      flashCount <= 0;
      seriesDone <= 1'b0;
    end else begin
      seriesDone <= 1'b0;
      prevRed <= lampRed;
      if (lampRed) begin
        offLen <= 0;
        if (!prevRed) cnt <= cnt + 1;
      end else begin
        offLen <= offLen + 1;
        if (offLen == GAP && cnt != 0) begin
          flashCount <= cnt;
          seriesDone <= 1'b1;
          cnt <= 0;
        end
      end
    end
  end
endmodule // fbsig_lamp_observer
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys, rst_b, busInitDone, faultValid, xferOk, wdogEnable;
  logic lampRed, lampGreen, fieldbus_failure_flag, seriesDone;
  fbsig_pkg::fbsig_fault_t faultIn;
  logic [63:0] moduleHasData;
  logic [5:0]  moduleIndex;
  logic [15:0] fbusOutputs, safeOutputs, fieldOutputs, fieldbusErrorWord;
  logic [3:0]  shownCode;
  logic [7:0]  shownArg;
  int          flashCount, fails, total_checks;
  logic [23:0] tbl [14] = '{24'h10D10D, 24'h10E000, 24'h203203, 24'h204000,
    24'h305300, 24'h400400, 24'h50050C, 24'h608608, 24'h609000, 24'h70170C,
    24'h800000, 24'h900000, 24'hA03A03, 24'hB01000};
  fbsig_signaller #(.PAUSE_CYCLES(20), .WDOG_CYCLES(10), .FAST_CYCLES(4),
    .SLOW_CYCLES(8), .STARTUP_CYCLES(30), .OUT_W(16)) i_fbsig_signaller (.*);
  fbsig_lamp_observer i_fbsig_lamp_observer (.clk_sys(clk_sys),
    .rst_b(rst_b), .lampRed(lampRed), .flashCount(flashCount),
    .seriesDone(seriesDone));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic do_reset;
    rst_b = 1'b0;
    tick(5);
    rst_b = 1'b1;
  endtask
  task automatic put_fault(input logic [3:0] c, input logic [7:0] a);
    faultIn.code = c;
    faultIn.arg = a;
    faultValid = 1'b1;
    tick(1);
    faultValid = 1'b0;
    tick(2);
  endtask
  task automatic pulse_xfer;
    xferOk = 1'b1;
    tick(1);
    xferOk = 1'b0;
    tick(1);
  endtask
  task automatic get_series(output int n);
    n = -1;
    for (int i = 0; i < 600 && n < 0; i++) begin
      tick(1);
      if (seriesDone === 1'b1) n = flashCount;
    end
    if (n < 0) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic s_watch;
    int i;
    logic r;
    busInitDone = 1'b0;
    do_reset();
    wdogEnable = 1'b1;
    tick(40);
    r = lampRed;
    tick(4);
    check(lampRed, !r);
    check(lampGreen, 1'b0);
    busInitDone = 1'b1;
    for (i = 0; i < 100 && lampGreen !== 1'b1; i++) tick(1);
    check(lampGreen, 1'b1);
    fbusOutputs = 16'hA5A5;
    pulse_xfer();
    check(fieldOutputs, 16'hA5A5);
    tick(6);
    check(fieldbus_failure_flag, 1'b0);
    tick(8);
    check(fieldbusErrorWord, 16'h0001);
    check(fieldOutputs, 16'h5A5A);
    pulse_xfer();
    check({fieldbus_failure_flag, fieldbusErrorWord}, 17'h0);
    wdogEnable = 1'b0;
    tick(20);
    check({fieldbus_failure_flag, fieldOutputs}, 17'h0A5A5);
  endtask
  task automatic s_table;
    foreach (tbl[i]) begin
      do_reset();
      put_fault(tbl[i][23:20], tbl[i][19:12]);
      check({shownCode, shownArg}, tbl[i][11:0]);
    end
  endtask
  task automatic s_blink;
    int n;
    do_reset();
    put_fault(4'h4, 8'h01);
    put_fault(4'h1, 8'h01);
    check({shownCode, shownArg}, 12'h40C);
    n = 0;
    for (int k = 0; k < 8 && n != 4; k++) get_series(n);
    get_series(n);
    check(n, 12);
    get_series(n);
    check(n, 10);
    get_series(n);
    check(n, 4);
  endtask
  initial begin
    fails = 0;
    total_checks = 0;
    rst_b = 1'b1;
    busInitDone = 1'b1;
    faultValid = 1'b0;
    faultIn = '0;
    moduleHasData = 64'h0000_0000_0000_1FF7;
    moduleIndex = 6'h0C;
    xferOk = 1'b0;
    wdogEnable = 1'b0;
    fbusOutputs = 16'h0000;
    safeOutputs = 16'h5A5A;
    // reset falls after time zero so every async reset sees the edge
    #2;
    s_watch();
    s_table();
    s_blink();
    stop_test();
  end
endmodule // testbench
bind fbsig_signaller fbsig_properties #(.WDOG_CYCLES(WDOG_CYCLES),
  .OUT_W(OUT_W)) i_fbsig_properties (.*);
`default_nettype wire
